// >>> inc/cii_defines.svh
`ifndef CII_DEFINES_SVH
`define CII_DEFINES_SVH

// register byte offsets
`define CII_OFS_DEV_INIT      8'h00
`define CII_OFS_CMP_LOAD      8'h04
`define CII_OFS_STATUS_PORT_THREE       8'h08
`define CII_OFS_IN_STATUS     8'h0c
`define CII_OFS_IRQ_STATUS    8'h10
`define CII_OFS_IRQ_MASK      8'h14
`define CII_OFS_COUNTER       8'h18

// field positions
`define CII_BIT_OUT_TYPE      0
`define CII_BIT_CMP_FLAG      0
`define CII_BIT_ST3_TYPE      1
`define CII_BIT_EV_DEV        0
`define CII_BIT_EV_IN         1

// widths and reset values
`define CII_N_INPUTS          4
`define CII_N_EVENTS          2
`define CII_RST_THRESHOLD     32'h0000_0000
`define CII_RST_MASK          2'h0
`define CII_RESP_OKAY         2'h0
`define CII_RESP_SLVERR       2'h2

`endif

// >>> inc/cii_pkg.sv
package cii_pkg;
	typedef logic [31:0] cii_word_t;
	typedef logic [1:0]  cii_resp_t;
	typedef logic [3:0]  cii_strb_t;
endpackage

// >>> inc/cii_dev_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries threshold, mode and status-read strobe between top and compare unit
interface cii_dev_if;
	import cii_pkg::*;
	cii_word_t threshold;
	logic      out_type;
	cii_word_t counter;
	logic      st3_read;
	logic      flag;
	modport ctl (output threshold, output out_type, output counter, output st3_read,
	             input flag);
	modport cmp (input threshold, input out_type, input counter, input st3_read,
	             output flag);
endinterface
`default_nettype wire

// >>> src/cii_in_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "cii_defines.svh"
// three-stage pin synchroniser with on-edge detection for active-low inputs
module cii_in_sync
	import cii_pkg::*;
(
	input  wire logic                      mclk,
	input  wire logic                      resetn,
	input  wire logic [`CII_N_INPUTS-1:0] general_input_line_n,
	output logic      [`CII_N_INPUTS-1:0] on_pulse
);
	logic [`CII_N_INPUTS-1:0] s1_r;
	logic [`CII_N_INPUTS-1:0] s2_r;
	logic [`CII_N_INPUTS-1:0] s3_r;
	logic [`CII_N_INPUTS-1:0] lvl_r;
	wire  [`CII_N_INPUTS-1:0] agree;
	wire  [`CII_N_INPUTS-1:0] lvl_nxt;

	// s1 only feeds s2; a change counts once s2 and s3 agree
	assign agree   = ~(s2_r ^ s3_r);
	assign lvl_nxt = (agree & s3_r) | (~agree & lvl_r);

	// pins idle high (off); reset to that so no false edge appears
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s1_r  <= '1;
			s2_r  <= '1;
			s3_r  <= '1;
			lvl_r <= '1;
		end else begin
			s1_r  <= general_input_line_n;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	// high-to-low transition means the input turned on
	assign on_pulse = lvl_r & ~lvl_nxt;
endmodule
`default_nettype wire

// >>> src/cii_dev_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// deviation compare: latched or through-output interrupt source
module cii_dev_cmp
	import cii_pkg::*;
(
	input  wire logic mclk,
	input  wire logic resetn,
	cii_dev_if.cmp    dif
);
	logic flag_r;
	logic match_r;
	wire  match;
	wire  hit;
	wire  flag_nxt;

	// match registered once so the rising edge marks reaching the threshold
	assign match    = (dif.counter == dif.threshold);
	assign hit      = match & ~match_r;
	// latched: set on reaching wins over a status read clear
	// through: follows the match, reads have no effect
	assign flag_nxt = dif.out_type ? match :
	                  (hit | (flag_r & ~dif.st3_read));

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			flag_r  <= 1'b0;
			match_r <= 1'b0;
		end else begin
			flag_r  <= flag_nxt;
			match_r <= match;
		end
	end

	assign dif.flag = flag_r;
endmodule
`default_nettype wire

// >>> src/cii_irq_top.sv
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cii_defines.svh"
// How it works
// - writing the initialise command with the output-type bit at 1 selects through-output.
// - the compare load command stores the deviation interrupt threshold.
// - the active-low deviation interrupt asserts when the counter reaches the threshold.
// - in through-output mode the interrupt stays asserted while the counter matches.
// - in through-output mode it releases once the counter stops matching, no read needed.
// - each input source has its own status flag set and cleared with the input request.
// - the input request asserts after a monitored input turns on.
// - the input request stays latched until the input status port is read; a write to it has no effect.
// - reading the input status port clears the input request and its flags.
// - in latched mode the deviation interrupt holds until status port three is read.
module cii_irq_top
	import cii_pkg::*;
(
	input  wire logic                      mclk,
	input  wire logic                      resetn,
	// axi4-lite slave
	input  wire logic [7:0]                s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [7:0]                s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// position deviation counter value, same clock domain
	input  wire logic [31:0]               position_deviation_counter,
	// active-low general inputs from the pins
	input  wire logic [`CII_N_INPUTS-1:0] general_input_line_n,
	// interrupt outputs
	output logic                           deviation_irq_n,
	output logic                           input_event_irq,
	output logic                           irq
);

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------

	// byte-lane merge of a write into an existing word
	function automatic cii_word_t merge_bytes(input cii_word_t old_v,
	                                          input cii_word_t new_v,
	                                          input cii_strb_t strb);
		cii_word_t res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// true when an address names one of the mapped registers
	function automatic logic addr_mapped(input logic [7:0] a);
		return (a == `CII_OFS_DEV_INIT)   || (a == `CII_OFS_CMP_LOAD) ||
		       (a == `CII_OFS_STATUS_PORT_THREE)    || (a == `CII_OFS_IN_STATUS) ||
		       (a == `CII_OFS_IRQ_STATUS) || (a == `CII_OFS_IRQ_MASK) ||
		       (a == `CII_OFS_COUNTER);
	endfunction

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------

	logic [7:0]                awaddr_r;
	logic                      aw_hold_r;
	cii_word_t                 wdata_r;
	cii_strb_t                 wstrb_r;
	logic                      w_hold_r;
	logic                      bvalid_r;
	cii_resp_t                 bresp_r;
	logic                      rvalid_r;
	cii_word_t                 rdata_r;
	cii_resp_t                 rresp_r;

	cii_word_t                 threshold_r;
	logic                      out_type_r;
	logic [`CII_N_INPUTS-1:0] in_flag_r;
	logic [`CII_N_INPUTS-1:0] in_flag_nxt;
	logic [`CII_N_EVENTS-1:0] ev_status_r;
	logic [`CII_N_EVENTS-1:0] ev_status_nxt;
	logic [`CII_N_EVENTS-1:0] ev_mask_r;
	logic                      dev_flag_d_r;
	logic                      in_irq_d_r;

	wire                       aw_hs;
	wire                       w_hs;
	wire                       ar_hs;
	wire                       do_write;
	wire                       wr_mapped;
	wire                       rd_mapped;
	wire                       wr_dev_init;
	wire                       wr_cmp_load;
	wire                       wr_irq_status;
	wire                       wr_irq_mask;
	wire                       rd_status_port_three;
	wire                       rd_in_status;
	wire [`CII_N_INPUTS-1:0]  in_on;
	wire                       dev_rise;
	wire                       in_rise;
	wire [`CII_N_EVENTS-1:0]  ev_set;
	wire [`CII_N_EVENTS-1:0]  ev_clr;
	cii_word_t                 rd_mux;

	cii_dev_if dif ();

	// ------------------------------------------------------------
	// axi4-lite handshakes
	// ------------------------------------------------------------

	// address and data are taken in either order; a channel stops
	// accepting once it holds an item or a response is pending
	assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
	assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
	assign s_axi_arready = ~rvalid_r;
	assign aw_hs         = s_axi_awvalid & s_axi_awready;
	assign w_hs          = s_axi_wvalid & s_axi_wready;
	assign ar_hs         = s_axi_arvalid & s_axi_arready;
	assign do_write      = aw_hold_r & w_hold_r & ~bvalid_r;

	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	// write address and data capture
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			aw_hold_r <= 1'b0;
			awaddr_r  <= 8'h00;
		end else if (aw_hs) begin
			aw_hold_r <= 1'b1;
			awaddr_r  <= s_axi_awaddr;
		end else if (do_write) begin
			aw_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			w_hold_r <= 1'b0;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
		end else if (w_hs) begin
			w_hold_r <= 1'b1;
			wdata_r  <= s_axi_wdata;
			wstrb_r  <= s_axi_wstrb;
		end else if (do_write) begin
			w_hold_r <= 1'b0;
		end
	end

	// write response, raised on the same edge that performs the write
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= `CII_RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_mapped ? `CII_RESP_OKAY : `CII_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------

	// read-only ports ignore writes but still answer okay
	assign wr_mapped     = addr_mapped(awaddr_r);
	assign rd_mapped     = addr_mapped(s_axi_araddr);
	assign wr_dev_init   = do_write & (awaddr_r == `CII_OFS_DEV_INIT);
	assign wr_cmp_load   = do_write & (awaddr_r == `CII_OFS_CMP_LOAD);
	assign wr_irq_status = do_write & (awaddr_r == `CII_OFS_IRQ_STATUS);
	assign wr_irq_mask   = do_write & (awaddr_r == `CII_OFS_IRQ_MASK);
	// side-effect reads act on the address handshake edge
	assign rd_status_port_three    = ar_hs & (s_axi_araddr == `CII_OFS_STATUS_PORT_THREE);
	assign rd_in_status  = ar_hs & (s_axi_araddr == `CII_OFS_IN_STATUS);

	// ------------------------------------------------------------
	// command registers
	// ------------------------------------------------------------

	// initialise command sets the deviation output type
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			out_type_r <= 1'b0;
		end else if (wr_dev_init && wstrb_r[0]) begin
			out_type_r <= wdata_r[`CII_BIT_OUT_TYPE];
		end
	end

	// compare load command stores the threshold, byte lanes honoured
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			threshold_r <= `CII_RST_THRESHOLD;
		end else if (wr_cmp_load) begin
			threshold_r <= merge_bytes(threshold_r, wdata_r, wstrb_r);
		end
	end

	// ------------------------------------------------------------
	// deviation compare unit
	// ------------------------------------------------------------

	assign dif.threshold = threshold_r;
	assign dif.out_type  = out_type_r;
	assign dif.counter   = position_deviation_counter;
	assign dif.st3_read  = rd_status_port_three;

	cii_dev_cmp u_dev_cmp (
		.mclk   (mclk),
		.resetn (resetn),
		.dif    (dif)
	);

	// active-low pin view of the compare flag
	assign deviation_irq_n = ~dif.flag;

	// ------------------------------------------------------------
	// general input events
	// ------------------------------------------------------------

	cii_in_sync u_in_sync (
		.mclk                 (mclk),
		.resetn               (resetn),
		.general_input_line_n (general_input_line_n),
		.on_pulse             (in_on)
	);

	// a new turn-on in the same cycle as the read survives the clear
	assign in_flag_nxt = in_on | (in_flag_r & {`CII_N_INPUTS{~rd_in_status}});

	// per-source flags, latched until the status port is read
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			in_flag_r <= '0;
		end else begin
			in_flag_r <= in_flag_nxt;
		end
	end

	// shared request is the or of its flags, so both move together
	assign input_event_irq = |in_flag_r;

	// ------------------------------------------------------------
	// interrupt status and mask
	// ------------------------------------------------------------

	// events are rising edges of the two requests
	assign dev_rise = dif.flag & ~dev_flag_d_r;
	assign in_rise  = input_event_irq & ~in_irq_d_r;

	assign ev_set[`CII_BIT_EV_DEV] = dev_rise;
	assign ev_set[`CII_BIT_EV_IN]  = in_rise;
	assign ev_clr = wr_irq_status & wstrb_r[0] ?
	                wdata_r[`CII_N_EVENTS-1:0] : '0;
	// set wins over a write-one clear in the same cycle
	assign ev_status_nxt = ev_set | (ev_status_r & ~ev_clr);

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			dev_flag_d_r <= 1'b0;
			in_irq_d_r   <= 1'b0;
			ev_status_r  <= '0;
		end else begin
			dev_flag_d_r <= dif.flag;
			in_irq_d_r   <= input_event_irq;
			ev_status_r  <= ev_status_nxt;
		end
	end

	// mask register, a one enables the matching status bit
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ev_mask_r <= `CII_RST_MASK;
		end else if (wr_irq_mask && wstrb_r[0]) begin
			ev_mask_r <= wdata_r[`CII_N_EVENTS-1:0];
		end
	end

	assign irq = |(ev_status_r & ev_mask_r);

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------

	// read data mux; unused bits read as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (s_axi_araddr)
			`CII_OFS_DEV_INIT: begin
				rd_mux[`CII_BIT_OUT_TYPE] = out_type_r;
			end
			`CII_OFS_CMP_LOAD: begin
				rd_mux = threshold_r;
			end
			`CII_OFS_STATUS_PORT_THREE: begin
				rd_mux[`CII_BIT_CMP_FLAG] = dif.flag;
				rd_mux[`CII_BIT_ST3_TYPE] = out_type_r;
			end
			`CII_OFS_IN_STATUS: begin
				rd_mux[`CII_N_INPUTS-1:0] = in_flag_r;
			end
			`CII_OFS_IRQ_STATUS: begin
				rd_mux[`CII_N_EVENTS-1:0] = ev_status_r;
			end
			`CII_OFS_IRQ_MASK: begin
				rd_mux[`CII_N_EVENTS-1:0] = ev_mask_r;
			end
			`CII_OFS_COUNTER: begin
				rd_mux = position_deviation_counter;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// data are captured with the address, so a clearing read returns
	// the flags as they stood before the clear
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= `CII_RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_mux;
			rresp_r  <= rd_mapped ? `CII_RESP_OKAY : `CII_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// >>> bench/cii_irq_props.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------
// port checks of the interrupt block
// ---------------------------------
module cii_irq_props
	import cii_pkg::*;
(
	input wire logic        mclk,
	input wire logic        resetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] position_deviation_counter,
	input wire logic [3:0]  general_input_line_n,
	input wire logic        deviation_irq_n,
	input wire logic        input_event_irq
);
	logic       mode_r, pv_r, pa_r, match_r;
	logic [3:0] idle_r, ps_r;
	cii_word_t  thr_r, pd_r;
	// decodes; the bench offers both write halves together, so they are taken together
	wire logic       take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire logic       match = position_deviation_counter == thr_r;
	wire logic       rd_st3 = s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h08;
	wire logic       rd_in = s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h0c;
	wire logic [3:0] idle_nxt = !(&general_input_line_n) ? 4'h0 : idle_r + {3'h0, idle_r != 4'hf};
	// mode and threshold mirror, applied one edge after the take like the block
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			{mode_r, pv_r, pa_r, match_r} <= 4'h0;
			idle_r <= 4'h0;
			ps_r   <= 4'h0;
			thr_r  <= 32'h0000_0000;
			pd_r   <= 32'h0000_0000;
		end else begin
			pv_r    <= take && (s_axi_awaddr == 8'h00 || s_axi_awaddr == 8'h04);
			pa_r    <= s_axi_awaddr[2];
			pd_r    <= s_axi_wdata;
			ps_r    <= s_axi_wstrb;
			match_r <= match;
			idle_r  <= idle_nxt;
			// byte lanes honoured so a partial compare load cannot skew the mirror
			for (int i = 0; i < 4; i++) begin
				if (pv_r && pa_r && ps_r[i]) thr_r[i*8 +: 8] <= pd_r[i*8 +: 8];
			end
			if (pv_r && !pa_r && ps_r[0]) mode_r <= pd_r[0];
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	a_bus_wbusy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write channel open while response pending");
	a_bus_rbusy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read channel open while data pending");
	a_dev_latch_set: assert property (!mode_r && match && !match_r |=> !deviation_irq_n)
		else $error("latched deviation interrupt missed a match");
	a_dev_latch_hold: assert property (!mode_r && !deviation_irq_n && !rd_st3
		|=> !deviation_irq_n)
		else $error("latched deviation interrupt dropped without a read");
	a_dev_read_clear: assert property (!mode_r && rd_st3 && !(match && !match_r)
		|=> deviation_irq_n)
		else $error("status read did not clear deviation interrupt");
	a_dev_thru_on: assert property (mode_r && match |=> !deviation_irq_n)
		else $error("through mode interrupt missing during match");
	a_dev_thru_off: assert property (mode_r && !match |=> deviation_irq_n)
		else $error("through mode interrupt stuck after match");
	a_in_hold: assert property (input_event_irq && !rd_in |=> input_event_irq)
		else $error("input request dropped without a read");
	a_in_clear: assert property (rd_in && idle_r > 4'h8 |=> !input_event_irq)
		else $error("input status read did not clear request");
endmodule
`default_nettype wire

// >>> bench/cii_field_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// field side: counter and input pins
// ------------------------------------
// pins rest high as through a pull-up; low means the input is on
module cii_field_model
	import cii_pkg::*;
(
	input  wire logic      mclk,
	output var cii_word_t  counter,
	output var logic [3:0] pins_n
);
	initial begin
		counter = 32'h0000_0064;
		pins_n  = 4'hf;
	end
	// changes land just after an edge, as a counter in the same clock would
	task automatic step(input cii_word_t c, input logic [3:0] p);
		@(posedge mclk);
		counter <= c;
		pins_n  <= p;
	endtask
endmodule
`default_nettype wire

// >>> bench/cii_irq_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
bind cii_irq_top cii_irq_props u_cii_irq_props (.mclk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .position_deviation_counter,
	.general_input_line_n, .deviation_irq_n, .input_event_irq);
// ---------------------------
// register and pin level bench
// ---------------------------
module cii_irq_top_bench
	import cii_pkg::*;
;
	logic       mclk, resetn, awvalid, wvalid, bready, arvalid, rready;
	logic       awready, wready, bvalid, arready, rvalid, dev_n, in_irq, irq;
	logic [7:0] awaddr, araddr;
	logic [3:0] pins_n;
	cii_word_t  wdata, rdata, counter;
	cii_strb_t  wstrb;
	cii_resp_t  bresp, rresp;
	int         num_errors, tests_run, cycles;

	cii_irq_top u_cii_irq_top (.mclk(mclk), .resetn(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.position_deviation_counter(counter), .general_input_line_n(pins_n),
		.deviation_irq_n(dev_n), .input_event_irq(in_irq), .irq(irq));
	cii_field_model u_cii_field_model (.mclk(mclk), .counter(counter), .pins_n(pins_n));

	// 40 MHz clock
	initial mclk = 1'b0;
	always #12.5 mclk = ~mclk;

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// the whole run needs under two hundred cycles; anything near the ceiling is a hang
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			conclude();
		end
	end

	task automatic chk(input cii_word_t g, input cii_word_t e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chkb(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// write: both halves offered at once, each dropped when taken, then the response
	task automatic wrc(input logic [7:0] a, input cii_word_t d, input cii_resp_t er);
		@(posedge mclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge mclk); while (!bvalid);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	task automatic rdc(input logic [7:0] a, input cii_word_t e, input cii_resp_t er);
		@(posedge mclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge mclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge mclk); while (!rvalid);
		rready <= 1'b0;
		chk(rdata, e);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr} = 16'h0000;
		wdata  = 32'h0000_0000;
		wstrb  = 4'hf;
		resetn = 1'b0;
		cycles = 0;
		wt(5);
		resetn <= 1'b1;
		// reset values, unmapped address, read-only counter
		rdc(8'h04, 32'h0000_0000, 2'h0);
		rdc(8'h14, 32'h0000_0000, 2'h0);
		rdc(8'h1c, 32'h0000_0000, 2'h2);
		wrc(8'h1c, 32'h0000_0001, 2'h2);
		wrc(8'h18, 32'h0000_0000, 2'h0);
		rdc(8'h18, 32'h0000_0064, 2'h0);
		// partial strobes: only lane 1 of the threshold lands, lane 0 off leaves the mode
		wstrb <= 4'h2;
		wrc(8'h04, 32'haabb_ccdd, 2'h0);
		wrc(8'h00, 32'h0000_0001, 2'h0);
		wstrb <= 4'hf;
		rdc(8'h04, 32'h0000_cc00, 2'h0);
		rdc(8'h00, 32'h0000_0000, 2'h0);
		chkb(dev_n, 1'b1);
		chkb(irq, 1'b0);
		$display("test reset done");
		// latched deviation interrupt, cleared by a status read while still matching
		wrc(8'h04, 32'h0000_0055, 2'h0);
		rdc(8'h04, 32'h0000_0055, 2'h0);
		u_cii_field_model.step(32'h0000_0055, 4'hf);
		wt(3);
		chkb(dev_n, 1'b0);
		wt(4);
		chkb(dev_n, 1'b0);
		rdc(8'h08, 32'h0000_0001, 2'h0);
		wt(2);
		chkb(dev_n, 1'b1);
		rdc(8'h08, 32'h0000_0000, 2'h0);
		// event status is masked until enabled, then cleared by writing one
		chkb(irq, 1'b0);
		rdc(8'h10, 32'h0000_0001, 2'h0);
		wrc(8'h14, 32'h0000_0001, 2'h0);
		wt(2);
		chkb(irq, 1'b1);
		wrc(8'h10, 32'h0000_0001, 2'h0);
		wt(2);
		chkb(irq, 1'b0);
		$display("test latched done");
		// through-output mode follows the match and ignores reads
		wrc(8'h00, 32'h0000_0001, 2'h0);
		rdc(8'h00, 32'h0000_0001, 2'h0);
		wt(2);
		chkb(dev_n, 1'b0);
		rdc(8'h08, 32'h0000_0003, 2'h0);
		wt(2);
		chkb(dev_n, 1'b0);
		u_cii_field_model.step(32'h0000_0056, 4'hf);
		wt(3);
		chkb(dev_n, 1'b1);
		u_cii_field_model.step(32'h0000_0055, 4'hf);
		wt(3);
		chkb(dev_n, 1'b0);
		u_cii_field_model.step(32'h0000_0064, 4'hf);
		wrc(8'h00, 32'h0000_0000, 2'h0);
		$display("test through done");
		// inputs 0 and 2 turn on, then off; the request holds until the status read
		wrc(8'h14, 32'h0000_0002, 2'h0);
		u_cii_field_model.step(32'h0000_0064, 4'ha);
		wt(8);
		chkb(in_irq, 1'b1);
		chkb(irq, 1'b1);
		u_cii_field_model.step(32'h0000_0064, 4'hf);
		wt(10);
		chkb(in_irq, 1'b1);
		rdc(8'h0c, 32'h0000_0005, 2'h0);
		wt(2);
		chkb(in_irq, 1'b0);
		rdc(8'h0c, 32'h0000_0000, 2'h0);
		wrc(8'h10, 32'h0000_0002, 2'h0);
		wt(2);
		chkb(irq, 1'b0);
		$display("test inputs done");
		conclude();
	end
endmodule
`default_nettype wire
